// *** logic/uifc_pkg.sv ***
// Purpose: Shared constants for the UART interrupt, DMA request and flow control block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one aligned word per register
// Notes: Behaviour list below; field positions and offsets are used by name only
// Behaviour
// - Read-only masked pending word, fixed bit positions
// - Per-source mask bit, one enables, zero disables
// - Clear word: write one clears, zero ignored
// - Clear bit one clears the CTS interrupt
// - DMA control bit zero enables receive requests
// - DMA control bit one enables transmit requests
// - Bit three blocks receive requests on errors
// - Flow config bit zero enables software flow
// - Bits 2:1 pick receive flow character pairs
// - Bits 4:3 pick transmit flow character pairs
// - Bit five lets any character resume
// - Bit six enables special character detection
// - Two resume, two pause 8-bit character registers
// - All control words reset to zero
package uifc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MASK = 8'h38;
  localparam logic [7:0] OFS_RAW = 8'h3c;
  localparam logic [7:0] OFS_MASKED = 8'h40;
  localparam logic [7:0] OFS_CLEAR = 8'h44;
  localparam logic [7:0] OFS_DMA = 8'h48;
  localparam logic [7:0] OFS_FLOW = 8'h50;
  localparam logic [7:0] OFS_RES1 = 8'h54;
  localparam logic [7:0] OFS_RES2 = 8'h58;
  localparam logic [7:0] OFS_PAU1 = 8'h5c;
  localparam logic [7:0] OFS_PAU2 = 8'h60;
  localparam logic [7:0] OFS_FSTAT = 8'h64;
  // Interrupt word layout
  localparam int IRQ_W = 13;
  localparam logic [12:0] IRQ_IMPL = 13'h1ff2;
  localparam logic [12:0] IRQ_ERR = 13'h0780;
  localparam int BIT_CTS = 1;
  localparam int BIT_PAUSE = 11;
  // DMA control layout
  localparam int DMA_W = 4;
  localparam int DMA_RX_EN = 0;
  localparam int DMA_TX_EN = 1;
  localparam int DMA_STOP = 3;
  localparam logic [3:0] DMA_IMPL = 4'hb;
  // Flow config layout
  localparam int XF_W = 7;
  localparam int XF_EN = 0;
  localparam int XF_RX_LO = 1;
  localparam int XF_TX_LO = 3;
  localparam int XF_ANY = 5;
  localparam int XF_SPEC = 6;
  localparam logic [6:0] XF_IMPL = 7'h7f;
  // Pair select codes
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_FIRST = 2'h1;
  localparam logic [1:0] SEL_SECOND = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // Bus answer states
  typedef enum logic [1:0] {
    UIFC_IDLE = 2'b01,
    UIFC_ANSWER = 2'b10
  } uifc_bus_state_t;
endpackage

// *** logic/uifc_char_if.sv ***
// Purpose: Received character stream between the top and its matchers
// Assumes: Single clock, valid is a one-cycle strobe
// Notes: Source is the top, sinks are the matchers
`timescale 1ns/100ps
interface uifc_char_if #(parameter int CW = 8);
  logic [CW-1:0] data; // Character value
  logic valid; // Character strobe
  modport src (output data, output valid);
  modport snk (input data, input valid);
endinterface

// *** logic/uifc_char_match.sv ***
// Purpose: Compares a character with one or both programmed values
// Assumes: Select code chooses first, second or both values
// Notes: Combinational hit, qualified by the stream strobe
`timescale 1ns/100ps
module uifc_char_match import uifc_pkg::*; #(
  parameter int CW = 8
) (
  // Character stream
  uifc_char_if.snk chr,
  // Selection and values
  input wire logic [1:0] sel,
  input wire logic [CW-1:0] first,
  input wire logic [CW-1:0] second,
  // Result
  output logic hit
);
  // Hit on the values that the pair select names
  always_comb begin
    hit = 1'b0;
    case (sel)
      SEL_FIRST: hit = (chr.data == first);
      SEL_SECOND: hit = (chr.data == second);
      SEL_BOTH: hit = (chr.data == first) || (chr.data == second);
      default: hit = 1'b0;
    endcase
    hit = hit && chr.valid;
  end
endmodule

// *** logic/uifc_irq_bank.sv ***
// Purpose: Sticky raw interrupt bits with mask gating
// Assumes: Set and clear come from the same clock domain
// Notes: A set in the same cycle as its clear wins
`timescale 1ns/100ps
module uifc_irq_bank import uifc_pkg::*; #(
  parameter int W = IRQ_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Events and controls
  input wire logic [W-1:0] set_evt,
  input wire logic [W-1:0] clear,
  input wire logic [W-1:0] mask,
  // Status
  output logic [W-1:0] raw_q,
  output logic [W-1:0] masked
);
  logic [W-1:0] raw_reg; // Pending bits
  // Sticky pending bits, set beats clear
  always_ff @(posedge clock) begin
    if (reset) begin
      raw_reg <= '0;
    end else begin
      raw_reg <= (raw_reg & ~clear) | set_evt;
    end
  end
  assign raw_q = raw_reg;
  assign masked = raw_reg & mask;
endmodule

// *** logic/uifc_top.sv ***
// Purpose: UART interrupt status, DMA request gating and software flow control
// Assumes: UART core events, characters and FIFO levels share this clock
// Notes: Avalon-MM slave answers every access with one waitrequest-low cycle
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module uifc_top import uifc_pkg::*; #(
  parameter int CW = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // UART core events and levels
  input wire logic [IRQ_W-1:0] irq_event,
  input wire logic rx_char_valid,
  input wire logic [CW-1:0] rx_char_data,
  input wire logic rx_avail,
  input wire logic tx_space,
  input wire logic rx_fifo_high,
  // Interrupt and DMA requests
  output logic irq_out,
  output logic rx_dma_req,
  output logic tx_dma_req,
  // Flow control towards the transmitter
  output logic tx_hold,
  output logic send_char_req,
  output logic [CW-1:0] send_char_data,
  output logic special_char_seen
);
  // Bus state and answer
  uifc_bus_state_t state_reg; // Bus answer state
  logic wait_reg; // Waitrequest flop
  logic [31:0] rdata_reg; // Read data flop
  logic [31:0] rdata_next; // Selected read value
  logic [31:0] wmask; // Byte lane mask
  logic wr_go; // Write takes effect this edge
  // Software registers
  logic [IRQ_W-1:0] mask_reg; // Interrupt mask
  logic [DMA_W-1:0] dma_reg; // DMA request control
  logic [XF_W-1:0] flow_cfg_reg; // Soft flow config
  logic [CW-1:0] res1_reg; // First resume character
  logic [CW-1:0] res2_reg; // Second resume character
  logic [CW-1:0] pau1_reg; // First pause character
  logic [CW-1:0] pau2_reg; // Second pause character
  // Interrupt bank signals
  logic [IRQ_W-1:0] clr_w; // Clear bits from a write
  logic [IRQ_W-1:0] set_all; // Core events plus pause detect
  logic [IRQ_W-1:0] raw_q; // Raw pending
  logic [IRQ_W-1:0] masked_w; // Masked pending
  // Output and flow state flops
  logic irq_reg; // Interrupt output
  logic rxdma_reg; // Receive DMA request
  logic txdma_reg; // Transmit DMA request
  logic hold_reg; // Transmit paused
  logic send_reg; // Send flow character strobe
  logic [CW-1:0] send_data_reg; // Flow character to send
  logic spec_reg; // Special character strobe
  logic high_prev_reg; // Receive FIFO level, last cycle
  // Decoded controls
  logic flow_on; // Global flow enable
  logic [1:0] rx_sel; // Receive pair select
  logic [1:0] tx_sel; // Transmit pair select
  logic tx_flow_on; // Transmit flow active
  logic rx_flow_on; // Receive flow active
  logic pause_hit; // Received pause character
  logic resume_hit; // Received resume character
  logic resume_ok; // Resume accepted
  logic err_any; // Any masked error pending
  logic rx_dma_next; // Receive DMA request next
  logic tx_dma_next; // Transmit DMA request next
  logic spec_next; // Special character seen next

  // Received character stream shared by the matchers
  uifc_char_if #(.CW(CW)) rx_chr ();
  assign rx_chr.data = rx_char_data;
  assign rx_chr.valid = rx_char_valid;

  // Byte lanes of a write
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // A write lands at the edge where waitrequest is seen low
  assign wr_go = (state_reg == UIFC_ANSWER) && avs_write;

  // Bus handshake: one answer cycle per request
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= UIFC_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= RST_ZERO;
    end else begin
      case (state_reg)
        UIFC_IDLE: begin
          // Request seen: drop waitrequest with data ready
          if (avs_read || avs_write) begin
            state_reg <= UIFC_ANSWER;
            wait_reg <= 1'b0;
            rdata_reg <= avs_read ? rdata_next : RST_ZERO;
          end
        end
        UIFC_ANSWER: begin
          // Access completes, back to waiting
          state_reg <= UIFC_IDLE;
          wait_reg <= 1'b1;
        end
        default: begin
          state_reg <= UIFC_IDLE;
          wait_reg <= 1'b1;
        end
      endcase
    end
  end

  // Read mux; unmapped and write-only words read as zero
  always_comb begin
    rdata_next = RST_ZERO;
    case (avs_address)
      OFS_MASK: rdata_next[IRQ_W-1:0] = mask_reg;
      OFS_RAW: rdata_next[IRQ_W-1:0] = raw_q;
      OFS_MASKED: rdata_next[IRQ_W-1:0] = masked_w;
      OFS_DMA: rdata_next[DMA_W-1:0] = dma_reg;
      OFS_FLOW: rdata_next[XF_W-1:0] = flow_cfg_reg;
      OFS_RES1: rdata_next[CW-1:0] = res1_reg;
      OFS_RES2: rdata_next[CW-1:0] = res2_reg;
      OFS_PAU1: rdata_next[CW-1:0] = pau1_reg;
      OFS_PAU2: rdata_next[CW-1:0] = pau2_reg;
      OFS_FSTAT: rdata_next[0] = hold_reg;
      default: rdata_next = RST_ZERO;
    endcase
  end

  // Mask and control words; reserved bits are never stored
  always_ff @(posedge clock) begin
    if (reset) begin
      mask_reg <= '0;
      dma_reg <= '0;
      flow_cfg_reg <= '0;
    end else if (wr_go) begin
      if (avs_address == OFS_MASK) begin
        mask_reg <= ((mask_reg & ~wmask[IRQ_W-1:0]) |
                     (avs_writedata[IRQ_W-1:0] & wmask[IRQ_W-1:0])) & IRQ_IMPL;
      end
      if (avs_address == OFS_DMA) begin
        dma_reg <= ((dma_reg & ~wmask[DMA_W-1:0]) |
                    (avs_writedata[DMA_W-1:0] & wmask[DMA_W-1:0])) & DMA_IMPL;
      end
      if (avs_address == OFS_FLOW) begin
        flow_cfg_reg <= ((flow_cfg_reg & ~wmask[XF_W-1:0]) |
                         (avs_writedata[XF_W-1:0] & wmask[XF_W-1:0])) & XF_IMPL;
      end
    end
  end

  // Flow character values, low byte lane only
  always_ff @(posedge clock) begin
    if (reset) begin
      res1_reg <= '0;
      res2_reg <= '0;
      pau1_reg <= '0;
      pau2_reg <= '0;
    end else if (wr_go && avs_byteenable[0]) begin
      if (avs_address == OFS_RES1) res1_reg <= avs_writedata[CW-1:0];
      if (avs_address == OFS_RES2) res2_reg <= avs_writedata[CW-1:0];
      if (avs_address == OFS_PAU1) pau1_reg <= avs_writedata[CW-1:0];
      if (avs_address == OFS_PAU2) pau2_reg <= avs_writedata[CW-1:0];
    end
  end

  // Clear word: ones clear, zeros do nothing, CTS at its own bit
  assign clr_w = (wr_go && avs_address == OFS_CLEAR) ?
                 (avs_writedata[IRQ_W-1:0] & wmask[IRQ_W-1:0] & IRQ_IMPL) : '0;

  // Pause detection feeds its own pending bit
  always_comb begin
    set_all = irq_event & IRQ_IMPL;
    set_all[BIT_PAUSE] = irq_event[BIT_PAUSE] || (tx_flow_on && pause_hit);
  end

  // Sticky pending bits and mask gating
  uifc_irq_bank #(.W(IRQ_W)) u_bank (
    .clock(clock),
    .reset(reset),
    .set_evt(set_all),
    .clear(clr_w),
    .mask(mask_reg),
    .raw_q(raw_q),
    .masked(masked_w)
  );

  // Decoded flow controls
  assign flow_on = flow_cfg_reg[XF_EN];
  assign rx_sel = flow_cfg_reg[XF_RX_LO+1:XF_RX_LO];
  assign tx_sel = flow_cfg_reg[XF_TX_LO+1:XF_TX_LO];
  assign tx_flow_on = flow_on && (tx_sel != SEL_OFF);
  assign rx_flow_on = flow_on && (rx_sel != SEL_OFF);

  // Pause characters from the peer, per the transmit pair select
  uifc_char_match #(.CW(CW)) u_pause (
    .chr(rx_chr),
    .sel(tx_sel),
    .first(pau1_reg),
    .second(pau2_reg),
    .hit(pause_hit)
  );

  // Resume characters from the peer, per the transmit pair select
  uifc_char_match #(.CW(CW)) u_resume (
    .chr(rx_chr),
    .sel(tx_sel),
    .first(res1_reg),
    .second(res2_reg),
    .hit(resume_hit)
  );

  // Any character resumes when that option is on
  assign resume_ok = flow_cfg_reg[XF_ANY] ? rx_char_valid : resume_hit;

  // Transmit hold: pause wins over a resume in the same character
  always_ff @(posedge clock) begin
    if (reset) begin
      hold_reg <= 1'b0;
    end else if (!tx_flow_on) begin
      hold_reg <= 1'b0;
    end else if (pause_hit) begin
      hold_reg <= 1'b1;
    end else if (resume_ok) begin
      hold_reg <= 1'b0;
    end
  end

  // Receive flow: send pause on FIFO high, resume when it drains
  always_ff @(posedge clock) begin
    if (reset) begin
      high_prev_reg <= 1'b0;
      send_reg <= 1'b0;
      send_data_reg <= '0;
    end else begin
      high_prev_reg <= rx_fifo_high;
      send_reg <= rx_flow_on && (rx_fifo_high != high_prev_reg);
      if (rx_fifo_high && !high_prev_reg) begin
        send_data_reg <= (rx_sel == SEL_SECOND) ? pau2_reg : pau1_reg;
      end else if (!rx_fifo_high && high_prev_reg) begin
        send_data_reg <= (rx_sel == SEL_SECOND) ? res2_reg : res1_reg;
      end
    end
  end

  // Special character: received value equals any programmed one
  assign spec_next = flow_cfg_reg[XF_SPEC] && rx_char_valid &&
                     ((rx_char_data == res1_reg) || (rx_char_data == res2_reg) ||
                      (rx_char_data == pau1_reg) || (rx_char_data == pau2_reg));

  // DMA request gating
  assign err_any = |(masked_w & IRQ_ERR);
  assign rx_dma_next = dma_reg[DMA_RX_EN] && rx_avail &&
                       !(dma_reg[DMA_STOP] && err_any);
  assign tx_dma_next = dma_reg[DMA_TX_EN] && tx_space;

  // Registered outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_reg <= 1'b0;
      rxdma_reg <= 1'b0;
      txdma_reg <= 1'b0;
      spec_reg <= 1'b0;
    end else begin
      irq_reg <= |masked_w;
      rxdma_reg <= rx_dma_next;
      txdma_reg <= tx_dma_next;
      spec_reg <= spec_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign irq_out = irq_reg;
  assign rx_dma_req = rxdma_reg;
  assign tx_dma_req = txdma_reg;
  assign tx_hold = hold_reg;
  assign send_char_req = send_reg;
  assign send_char_data = send_data_reg;
  assign special_char_seen = spec_reg;

  // Interrupt output follows the masked word one cycle later
  property p_irq_or;
    @(posedge clock) disable iff (reset) 1'b1 |=> (irq_out == (|$past(masked_w)));
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not OR of masked");

  // Masked word never shows a bit whose mask is off
  property p_mis_gated;
    @(posedge clock) disable iff (reset) (masked_w & ~mask_reg) == '0;
  endproperty
  a_mis_gated: assert property (p_mis_gated) else $error("masked bit leaks");

  // A clear removes bits with no coincident event
  property p_clear;
    @(posedge clock) disable iff (reset)
      (clr_w != '0) |=> ((raw_q & $past(clr_w) & ~$past(set_all)) == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not clear");

  // An event coinciding with its clear is kept
  property p_set_wins;
    @(posedge clock) disable iff (reset)
      (clr_w[BIT_CTS] && set_all[BIT_CTS]) |=> raw_q[BIT_CTS];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

  // Stop on error blocks receive requests
  property p_rx_stop;
    @(posedge clock) disable iff (reset)
      (dma_reg[DMA_STOP] && err_any) |=> !rx_dma_req;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("rx dma during error");

  // Transmit requests need their enable
  property p_tx_en;
    @(posedge clock) disable iff (reset)
      tx_dma_req |-> $past(dma_reg[DMA_TX_EN]) && $past(tx_space);
  endproperty
  a_tx_en: assert property (p_tx_en) else $error("tx dma without enable");

  // Pause character holds transmit and raises its bit
  property p_pause;
    @(posedge clock) disable iff (reset)
      (tx_flow_on && pause_hit) |=> (tx_hold && raw_q[BIT_PAUSE]);
  endproperty
  a_pause: assert property (p_pause) else $error("pause not taken");

  // Valid resume releases the hold
  property p_resume;
    @(posedge clock) disable iff (reset)
      (tx_hold && !pause_hit && resume_ok) |=> !tx_hold;
  endproperty
  a_resume: assert property (p_resume) else $error("resume not taken");

  // Each request gets exactly one waitrequest-low cycle
  property p_answer;
    @(posedge clock) disable iff (reset)
      (state_reg == UIFC_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bad bus answer");

  // Detection off means no special strobe
  property p_spec_off;
    @(posedge clock) disable iff (reset) !flow_cfg_reg[XF_SPEC] |=> !special_char_seen;
  endproperty
  a_spec_off: assert property (p_spec_off) else $error("special while off");
endmodule

// *** dv/uifc_peer.sv ***
// Purpose: Remote serial peer that hands received characters to the block
// Assumes: One character per strobe, strobe lasts one clock
// Notes: Once the strobe is gone the data line shows the inverted value
`timescale 1ns/100ps
module uifc_peer (
  // Clock
  input wire logic clock,
  // Received character stream
  output logic rx_char_valid,
  output logic [7:0] rx_char_data
);
  // Idle stream at time zero
  initial begin
    rx_char_valid = 1'b0;
    rx_char_data = 8'h00;
  end
  // Sends one character as a single-cycle strobe
  task automatic send(input logic [7:0] c);
    @(posedge clock);
    rx_char_valid <= 1'b1;
    rx_char_data <= c;
    @(posedge clock);
    rx_char_valid <= 1'b0;
    // Stale data must not pass for a fresh character
    rx_char_data <= ~c;
  endtask
endmodule

// *** dv/uifc_top_test.sv ***
// Purpose: Self-checking bench for interrupt status, DMA gating and flow control
// Assumes: Avalon-MM master waits for waitrequest low, 10 MHz clock
// Notes: Pause chars 13/93, resume chars 11/91 are programmed after the interrupt and DMA checks
`timescale 1ns/100ps
module uifc_top_test import uifc_pkg::*;;
  // Clock, reset and bus
  logic clock, reset, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  // Core side
  logic [12:0] irq_event;
  logic rx_char_valid, rx_avail, tx_space, rx_fifo_high;
  logic [7:0] rx_char_data, send_char_data, last_sent;
  logic irq_out, rx_dma_req, tx_dma_req, tx_hold, send_char_req, special_char_seen;
  logic [1:0] sel;
  // Bookkeeping
  int n_fail, n_tests, n_spec, n_send, n0;

  uifc_top #(.CW(8)) uut (.clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_event(irq_event), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_avail(rx_avail), .tx_space(tx_space), .rx_fifo_high(rx_fifo_high),
    .irq_out(irq_out), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req),
    .tx_hold(tx_hold), .send_char_req(send_char_req), .send_char_data(send_char_data),
    .special_char_seen(special_char_seen));
  uifc_peer peer (.clock(clock), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data));

  // Clock generator
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Counts flow pulses and keeps the last character asked for
  always @(posedge clock) begin
    if (special_char_seen === 1'b1) n_spec <= n_spec + 1;
    if (send_char_req === 1'b1) begin
      n_send <= n_send + 1;
      last_sent <= send_char_data;
    end
  end

  // Prints counts and verdict, then stops
  task automatic print_verdict();
    $display("tests=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Word comparison
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single output comparison, after the output has settled
  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus access, held until waitrequest is sampled low
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
  endtask
  // Register write and checked read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus_xfer(1'b0, a, 32'h0000_0000);
    check_word(q, exp);
  endtask
  // Event pulses from the core, then time for irq_out to follow
  task automatic pulse_irq(input logic [12:0] b);
    @(posedge clock);
    irq_event <= b;
    @(posedge clock);
    irq_event <= 13'h0000;
    repeat (2) @(posedge clock);
  endtask
  // Character from the peer, then transmit hold compared
  task automatic chr_hold(input logic [7:0] c, input logic exp);
    peer.send(c);
    repeat (3) @(posedge clock);
    check_bit(tx_hold, exp);
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {irq_event, rx_avail, tx_space, rx_fifo_high} = '0;
    {n_fail, n_tests, n_spec, n_send} = '0;
    last_sent = 8'h00;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    // Everything starts cleared
    rd_chk(OFS_DMA, RST_ZERO);
    rd_chk(OFS_FLOW, RST_ZERO);
    rd_chk(OFS_MASKED, RST_ZERO);
    check_bit(tx_hold | rx_dma_req | tx_dma_req | irq_out, 1'b0);
    rd_chk(8'h70, 32'h0000_0000);
    // Masking, status and clearing
    wr(OFS_MASK, 32'h0000_1ff2);
    rd_chk(OFS_MASK, 32'h0000_1ff2);
    pulse_irq(13'h1fff);
    rd_chk(OFS_MASKED, 32'h0000_1ff2);
    check_bit(irq_out, 1'b1);
    wr(OFS_MASK, 32'h0000_0010);
    rd_chk(OFS_MASKED, 32'h0000_0010);
    wr(OFS_CLEAR, 32'h0000_0000);
    rd_chk(OFS_RAW, 32'h0000_1ff2);
    wr(OFS_CLEAR, 32'h0000_0002);
    rd_chk(OFS_RAW, 32'h0000_1ff0);
    wr(OFS_CLEAR, 32'h0000_0010);
    repeat (2) @(posedge clock);
    check_bit(irq_out, 1'b0);
    rd_chk(OFS_MASKED, 32'h0000_0000);
    rd_chk(OFS_CLEAR, 32'h0000_0000);
    wr(OFS_CLEAR, 32'h0000_1fe0);
    rd_chk(OFS_RAW, 32'h0000_0000);
    // DMA request gating
    @(posedge clock);
    rx_avail <= 1'b1;
    tx_space <= 1'b1;
    wr(OFS_DMA, 32'h0000_0001);
    repeat (3) @(posedge clock);
    check_bit(rx_dma_req, 1'b1);
    check_bit(tx_dma_req, 1'b0);
    wr(OFS_DMA, 32'h0000_0002);
    repeat (3) @(posedge clock);
    check_bit(rx_dma_req, 1'b0);
    check_bit(tx_dma_req, 1'b1);
    wr(OFS_MASK, 32'h0000_1ff2);
    wr(OFS_DMA, 32'h0000_0009);
    rd_chk(OFS_DMA, 32'h0000_0009);
    pulse_irq(13'h0080);
    repeat (2) @(posedge clock);
    check_bit(rx_dma_req, 1'b0);
    wr(OFS_DMA, 32'h0000_0001);
    repeat (3) @(posedge clock);
    check_bit(rx_dma_req, 1'b1);
    wr(OFS_CLEAR, 32'h0000_1ff2);
    // Event landing on the same edge as its clear survives
    fork
      wr(OFS_CLEAR, 32'h0000_0002);
      begin
        repeat (2) @(posedge clock);
        irq_event <= 13'h0002;
        @(posedge clock);
        irq_event <= 13'h0000;
      end
    join
    rd_chk(OFS_RAW, 32'h0000_0002);
    wr(OFS_CLEAR, 32'h0000_0002);
    // Flow characters
    wr(OFS_PAU1, 32'h0000_0013);
    wr(OFS_PAU2, 32'h0000_0093);
    wr(OFS_RES1, 32'h0000_0011);
    wr(OFS_RES2, 32'h0000_0091);
    rd_chk(OFS_PAU2, 32'h0000_0093);
    // Transmit flow for each pair select
    for (int s = 1; s < 4; s++) begin
      sel = 2'(s);
      wr(OFS_FLOW, {27'h000_0000, sel, 3'b001});
      chr_hold(8'h13, sel[0]);
      chr_hold(8'h93, 1'b1);
      chr_hold(8'h41, 1'b1);
      chr_hold(8'h11, sel == 2'h2);
      chr_hold(8'h91, 1'b0);
    end
    rd_chk(OFS_RAW, 32'h0000_0800);
    wr(OFS_CLEAR, 32'h0000_0800);
    // Any character resumes
    wr(OFS_FLOW, 32'h0000_0029);
    rd_chk(OFS_FLOW, 32'h0000_0029);
    chr_hold(8'h13, 1'b1);
    rd_chk(OFS_FSTAT, 32'h0000_0001);
    chr_hold(8'h41, 1'b0);
    // Flow off, then transmit select off
    wr(OFS_FLOW, 32'h0000_0008);
    chr_hold(8'h13, 1'b0);
    wr(OFS_FLOW, 32'h0000_0001);
    chr_hold(8'h13, 1'b0);
    // Special character detection on and off
    wr(OFS_FLOW, 32'h0000_0041);
    n0 = n_spec;
    chr_hold(8'h91, 1'b0);
    check_word(32'(n_spec), 32'(n0 + 1));
    wr(OFS_FLOW, 32'h0000_0001);
    chr_hold(8'h91, 1'b0);
    check_word(32'(n_spec), 32'(n0 + 1));
    // Receive flow: pause on high level, resume on its fall
    for (int s = 0; s < 4; s++) begin
      wr(OFS_FLOW, 32'(2 * s + 1));
      n0 = n_send;
      @(posedge clock);
      rx_fifo_high <= 1'b1;
      repeat (3) @(posedge clock);
      check_word(32'(n_send), 32'(n0 + (s != 0)));
      if (s != 0) check_word({24'h00_0000, last_sent}, (s == 2) ? 32'h93 : 32'h13);
      rx_fifo_high <= 1'b0;
      repeat (3) @(posedge clock);
      if (s != 0) check_word({24'h00_0000, last_sent}, (s == 2) ? 32'h91 : 32'h11);
    end
    print_verdict();
  end
endmodule
